/* testbench/lbts_partner.sv */
// Behavioural argument, constant and lookup table sources
`timescale 1ns/100ps
module lbts_partner
	import lbts_pkg::*;
(
	input wire lbts_req_type i_req,
	input wire logic [7:0] i_lut_idx,
	output lbts_arg_type o_arg1,
	output lbts_arg_type o_arg2,
	output logic [31:0] o_const,
	output lbts_lut_type o_lut
);
	// Source 0e is in error, 0f unavailable, others yield their number
	function automatic lbts_arg_type src_val(input logic [7:0] s, input logic [7:0] n);
		src_val = '{{24'h000000, n}, s == 8'h0e, s == 8'h0f};
	endfunction : src_val
	assign o_arg1 = src_val(i_req.arg1_src, i_req.arg1_num);
	assign o_arg2 = src_val(i_req.arg2_src, i_req.arg2_num);
	// Constants share the integer scale of every argument
	assign o_const = {24'h000000, i_req.arg2_num};
	// Table 09 has no axis source
	assign o_lut = '{{24'h000000, i_lut_idx}, i_lut_idx == 8'h09};
endmodule : lbts_partner

/* testbench/lbts_props.sv */
// Concurrent checks on the selector ports
`timescale 1ns/100ps
module lbts_props
	import lbts_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic [9:0] i_addr,
	input wire logic [7:0] i_wr_data,
	input wire logic i_wr_stb,
	input wire logic i_rd_stb,
	input wire logic [7:0] o_rd_data,
	input wire lbts_out_type [NUM_BLK-1:0] o_block_out,
	input wire logic [NUM_BLK-1:0][1:0] o_selected_table
);
	logic [3:0] en_q;
	logic [5:0] dcnt_q;
	// Shadow of the enable bits, so no peeking inside the design is needed
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			en_q <= 4'h0;
			dcnt_q <= 6'h00;
		end else begin
			if (i_wr_stb && i_addr == ADDR_ENABLE)
				en_q <= i_wr_data[3:0];
			if (en_q[0])
				dcnt_q <= 6'h00;
			else if (dcnt_q != 6'h3f)
				dcnt_q <= dcnt_q + 6'h01;
		end
	end
	default clocking @(posedge i_ref_clk);
	endclocking
	default disable iff (i_sys_rst);
	highest_rd_a: assert property (i_rd_stb && i_addr == 10'h008 |=>
		o_rd_data == COND_HIGHEST_INDEX) else $error("highest index read wrong");
	unmapped_rd_a: assert property (i_rd_stb && !i_addr[9] && i_addr[2:1] == 2'h3 |=>
		o_rd_data == 8'h00) else $error("unmapped read not zero");
	enable_rd_a: assert property (i_rd_stb && i_addr == ADDR_ENABLE |=>
		o_rd_data == {4'h0, $past(en_q)}) else $error("enable read wrong");
	sel_rd_a: assert property (i_rd_stb && i_addr == 10'h230 |=>
		o_rd_data == {6'h00, $past(o_selected_table[0])}) else $error("selected read wrong");
	out_rd_a: assert property (i_rd_stb && i_addr == 10'h240 |=>
		o_rd_data == $past(o_block_out[0].value[7:0])) else $error("output read wrong");
	out_src_a: assert property ($fell(o_block_out[0].not_avail) |->
		$past(o_selected_table[0]) != TABLE_NONE) else $error("output without table");
	sel_hold_a: assert property ($changed(o_selected_table[0]) |=>
		$stable(o_selected_table[0]) [*8]) else $error("selection changed mid sweep");
	idle_off_a: assert property (dcnt_q > 6'h30 && !en_q[0] |->
		o_selected_table[0] == TABLE_NONE && o_block_out[0].not_avail)
		else $error("disabled block active");
endmodule : lbts_props

/* testbench/lbts_selector_tb_top.sv */
// Self-checking bench of the logic block table selector
`timescale 1ns/100ps
module lbts_selector_tb_top
	import lbts_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [9:0] addr = 10'h000;
	logic [7:0] wd = 8'h00;
	logic ws = 1'b0;
	logic rs = 1'b0;
	logic [7:0] rdat;
	lbts_req_type req;
	lbts_arg_type a1;
	lbts_arg_type a2;
	logic [31:0] cv;
	logic [7:0] li;
	lbts_lut_type lut;
	lbts_out_type [NUM_BLK-1:0] bo;
	logic [NUM_BLK-1:0][1:0] sel;
	int miscompares = 0;
	int checked = 0;
	int cyc = 0;
	logic [5:0] pats [7] = '{6'h15, 6'h1f, 6'h19, 6'h01, 6'h14, 6'h24, 6'h3f};
	always #12.5 clk = ~clk;
	lbts_selector lbts_selector_i (.i_ref_clk(clk), .i_sys_rst(rst), .i_addr(addr),
		.i_wr_data(wd), .i_wr_stb(ws), .i_rd_stb(rs), .o_rd_data(rdat), .o_arg_req(req),
		.i_arg1(a1), .i_arg2(a2), .i_const_value(cv), .o_lut_idx(li), .i_lut(lut),
		.o_block_out(bo), .o_selected_table(sel));
	lbts_partner lbts_partner_i (.i_req(req), .i_lut_idx(li), .o_arg1(a1), .o_arg2(a2),
		.o_const(cv), .o_lut(lut));
	task automatic close_out;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out
	// Ceiling well above the roughly 6200 cycles the tests need
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 12000) begin
			miscompares = miscompares + 1;
			close_out();
		end
	end
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		ws <= 1'b1;
		@(posedge clk);
		ws <= 1'b0;
	endtask : wr
	task automatic rd(input logic [9:0] a, input logic [7:0] e, input string n);
		@(posedge clk);
		addr <= a;
		rs <= 1'b1;
		@(posedge clk);
		rs <= 1'b0;
		#1;
		chk(n, e, rdat);
	endtask : rd
	// Two full 36-cycle sweeps, so the selection and output have settled
	task automatic sel_chk(input logic [1:0] e, input string n);
		repeat (80) @(posedge clk);
		#1;
		chk(n, {6'h00, e}, {6'h00, sel[0]});
		chk(n, {6'h00, e}, bo[0].value[7:0]);
	endtask : sel_chk
	// Block 3 uses lookup tables 4, 5 and 6 out of reset
	task automatic blk_chk(input logic [1:0] e, input logic [7:0] v, input string n);
		repeat (80) @(posedge clk);
		#1;
		chk(n, {6'h00, e}, {6'h00, sel[3]});
		chk(n, v, bo[3].value[7:0]);
		chk(n, {6'h00, TABLE_NONE}, {6'h00, sel[0]});
	endtask : blk_chk
	task automatic cnd(input logic [1:0] c, input logic [7:0] s, input logic [7:0] k,
			input logic [7:0] op);
		wr({5'h00, c, 3'h1}, s);
		wr({5'h00, c, 3'h2}, 8'h05);
		wr({5'h00, c, 3'h3}, SRC_CONST);
		wr({5'h00, c, 3'h4}, k);
		wr({5'h00, c, 3'h5}, op);
	endtask : cnd
	function automatic logic cmpx(input logic [7:0] op, input logic [7:0] a, input logic [7:0] b);
		case (op)
			CMP_EQ: cmpx = a == b;
			CMP_NE: cmpx = a != b;
			CMP_GT: cmpx = a > b;
			CMP_GE: cmpx = a >= b;
			CMP_LT: cmpx = a < b;
			default: cmpx = a <= b;
		endcase
	endfunction : cmpx
	function automatic logic hit(input logic [7:0] m, input logic [5:0] p);
		logic [2:0] t;
		logic [2:0] n;
		t = {p[5:4] == RES_TRUE, p[3:2] == RES_TRUE, p[1:0] == RES_TRUE};
		n = t | {p[5:4] == RES_NA, p[3:2] == RES_NA, p[1:0] == RES_NA};
		case (m)
			LOGIC_AND_ALL: hit = &n;
			LOGIC_OR_ALL: hit = |t;
			LOGIC_AND_OR: hit = (t[0] & t[1]) | t[2];
			LOGIC_OR_AND: hit = (t[0] | t[1]) & t[2];
			default: hit = 1'b1;
		endcase
	endfunction : hit
	task automatic t_reset;
		wr(10'h008, 8'h00);
		rd(10'h008, COND_HIGHEST_INDEX, "highest");
		rd(10'h105, CMP_EQ, "oper");
		rd(10'h001, SRC_UNUSED, "src1");
		rd(10'h053, SRC_UNUSED, "src2");
		rd(ADDR_ENABLE, 8'h00, "enable");
		rd(10'h210, LOGIC_AND_ALL, "comb a");
		rd(10'h211, LOGIC_AND_ALL, "comb b");
		rd(10'h21e, LOGIC_DEFAULT, "comb c");
		rd(10'h007, 8'h00, "unmapped");
		sel_chk(TABLE_NONE, "idle");
		$display("test reset done");
	endtask : t_reset
	task automatic t_ops;
		wr(ADDR_ENABLE, 8'h01);
		wr(10'h210, LOGIC_OR_ALL);
		for (int op = 0; op < 6; op++)
			for (int k = 4; k < 7; k++) begin
				cnd(2'h0, 8'h01, 8'(k), 8'(op));
				sel_chk(cmpx(8'(op), 8'h05, 8'(k)) ? TABLE_A : TABLE_B, "op");
			end
		rd(10'h230, 8'h01, "sel reg");
		rd(10'h240, 8'h01, "out reg");
		$display("test ops done");
	endtask : t_ops
	task automatic t_comb;
		logic [1:0] r;
		wr(10'h211, LOGIC_DEFAULT);
		for (int m = 0; m < 5; m++) begin
			wr(10'h210, 8'(m));
			for (int i = 0; i < 7; i++) begin
				for (int c = 0; c < 3; c++) begin
					r = pats[i][2*c+:2];
					cnd(2'(c), r == RES_NA ? SRC_UNUSED : r == RES_ERROR ? 8'h0e : 8'h01,
						8'h05, r == RES_FALSE ? CMP_NE : CMP_EQ);
				end
				sel_chk(hit(8'(m), pats[i]) ? TABLE_A : TABLE_B, "comb");
			end
		end
		$display("test comb done");
	endtask : t_comb
	task automatic t_fall;
		wr(10'h210, LOGIC_OR_ALL);
		wr(10'h211, LOGIC_OR_ALL);
		wr(10'h212, LOGIC_OR_ALL);
		sel_chk(TABLE_A, "fallback");
		wr(10'h220, 8'h09);
		repeat (80) @(posedge clk);
		rd(10'h250, 8'h01, "no axis");
		wr(ADDR_ENABLE, 8'h00);
		sel_chk(TABLE_NONE, "disable");
		wr(10'h230, 8'hff);
		rd(10'h230, 8'h00, "ro sel");
		$display("test fall done");
	endtask : t_fall
	task automatic t_blk;
		wr(ADDR_ENABLE, 8'h08);
		blk_chk(TABLE_A, 8'h04, "blk3 a");
		wr(10'h21c, 8'h05);
		blk_chk(TABLE_B, 8'h05, "blk3 bad comb");
		wr(10'h21c, LOGIC_AND_ALL);
		wr(10'h181, 8'h01);
		wr(10'h182, 8'h05);
		wr(10'h183, SRC_CONST);
		wr(10'h184, 8'h06);
		blk_chk(TABLE_B, 8'h05, "blk3 b");
		wr(10'h21d, LOGIC_OR_ALL);
		blk_chk(TABLE_C, 8'h06, "blk3 c");
		$display("test blk done");
	endtask : t_blk
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_ops();
		t_comb();
		t_fall();
		t_blk();
		close_out();
	end
endmodule : lbts_selector_tb_top
bind lbts_selector lbts_props lbts_props_i (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
	.i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb),
	.o_rd_data(o_rd_data), .o_block_out(o_block_out), .o_selected_table(o_selected_table));

/* verilog/lbts_cond_mem.sv */
// Condition configuration store with a bus port and an evaluation port
`timescale 1ns/100ps
module lbts_cond_mem
	import lbts_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic i_wr_en,
	input wire logic [5:0] i_wr_idx,
	input wire logic [2:0] i_wr_sub,
	input wire logic [7:0] i_wr_data,
	input wire logic [5:0] i_bus_idx,
	input wire logic [2:0] i_bus_sub,
	output logic [7:0] o_bus_data,
	input wire logic [5:0] i_ev_idx,
	output lbts_cond_type o_ev_word
);
	typedef struct packed {
		lbts_cond_type [NUM_COND-1:0] mem;
		logic [7:0] bus_rd;
		lbts_cond_type ev_rd;
	} lbts_mem_state_type;

	lbts_mem_state_type q;
	lbts_mem_state_type d;
	lbts_cond_type bus_entry;

	assign bus_entry = q.mem[i_bus_idx];
	assign o_bus_data = q.bus_rd;
	assign o_ev_word = q.ev_rd;

	always_comb begin
		d = q;
		if (i_wr_en) begin
			unique case (i_wr_sub) // RL3
				SUB_ARG1_SRC: d.mem[i_wr_idx].arg1_src = i_wr_data;
				SUB_ARG1_NUM: d.mem[i_wr_idx].arg1_num = i_wr_data;
				SUB_ARG2_SRC: d.mem[i_wr_idx].arg2_src = i_wr_data;
				SUB_ARG2_NUM: d.mem[i_wr_idx].arg2_num = i_wr_data;
				SUB_OPERATOR: d.mem[i_wr_idx].oper = i_wr_data;
				default: ;
			endcase
		end
		unique case (i_bus_sub) // RL3
			SUB_HIGHEST: d.bus_rd = COND_HIGHEST_INDEX;
			SUB_ARG1_SRC: d.bus_rd = bus_entry.arg1_src;
			SUB_ARG1_NUM: d.bus_rd = bus_entry.arg1_num;
			SUB_ARG2_SRC: d.bus_rd = bus_entry.arg2_src;
			SUB_ARG2_NUM: d.bus_rd = bus_entry.arg2_num;
			SUB_OPERATOR: d.bus_rd = bus_entry.oper;
			default: d.bus_rd = 8'h00;
		endcase
		d.ev_rd = q.mem[i_ev_idx];
	end

	// Operator resets to equal and both sources to unused
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			q <= '{mem: {NUM_COND{COND_RESET}}, bus_rd: 8'h00, ev_rd: COND_RESET}; // RL8 RL9
		end else begin
			q <= d;
		end
	end
endmodule : lbts_cond_mem

/* verilog/lbts_pkg.sv */
// Shared constants, types and helpers of the logic block table selector
package lbts_pkg;
	localparam int NUM_BLK = 4;
	localparam int NUM_TBL = 3;
	localparam int NUM_CND = 3;
	localparam int NUM_COND = NUM_BLK * NUM_TBL * NUM_CND;
	localparam int BYTE_W = 8;

	localparam logic [7:0] COND_HIGHEST_INDEX = 8'h05;
	localparam logic [2:0] SUB_HIGHEST = 3'h0;
	localparam logic [2:0] SUB_ARG1_SRC = 3'h1;
	localparam logic [2:0] SUB_ARG1_NUM = 3'h2;
	localparam logic [2:0] SUB_ARG2_SRC = 3'h3;
	localparam logic [2:0] SUB_ARG2_NUM = 3'h4;
	localparam logic [2:0] SUB_OPERATOR = 3'h5;

	// Source codes; the numbering of the source list is not fixed here
	localparam logic [7:0] SRC_UNUSED = 8'h00;
	localparam logic [7:0] SRC_CONST = 8'h0a;

	localparam logic [7:0] CMP_EQ = 8'h00;
	localparam logic [7:0] CMP_NE = 8'h01;
	localparam logic [7:0] CMP_GT = 8'h02;
	localparam logic [7:0] CMP_GE = 8'h03;
	localparam logic [7:0] CMP_LT = 8'h04;
	localparam logic [7:0] CMP_LE = 8'h05;

	localparam logic [1:0] RES_FALSE = 2'h0;
	localparam logic [1:0] RES_TRUE = 2'h1;
	localparam logic [1:0] RES_ERROR = 2'h2;
	localparam logic [1:0] RES_NA = 2'h3;

	localparam logic [7:0] LOGIC_DEFAULT = 8'h00;
	localparam logic [7:0] LOGIC_AND_ALL = 8'h01;
	localparam logic [7:0] LOGIC_OR_ALL = 8'h02;
	localparam logic [7:0] LOGIC_AND_OR = 8'h03;
	localparam logic [7:0] LOGIC_OR_AND = 8'h04;

	localparam logic [1:0] TABLE_NONE = 2'h0;
	localparam logic [1:0] TABLE_A = 2'h1;
	localparam logic [1:0] TABLE_B = 2'h2;
	localparam logic [1:0] TABLE_C = 2'h3;
	localparam logic [1:0] IDX_LAST = 2'h2;

	localparam logic [2:0][7:0] OP_RESET = {LOGIC_DEFAULT, LOGIC_AND_ALL, LOGIC_AND_ALL};
	localparam logic [3:0][2:0][7:0] LUT_RESET = {
		{8'h06, 8'h05, 8'h04}, {8'h03, 8'h02, 8'h01},
		{8'h06, 8'h05, 8'h04}, {8'h03, 8'h02, 8'h01}};

	localparam logic [9:0] ADDR_ENABLE = 10'h200;
	localparam logic [5:0] PAGE_OP = 6'h21;
	localparam logic [5:0] PAGE_LUT = 6'h22;
	localparam logic [5:0] PAGE_SEL = 6'h23;
	localparam logic [5:0] PAGE_OUT = 6'h24;
	localparam logic [5:0] PAGE_NA = 6'h25;

	typedef struct packed {
		logic [7:0] arg1_src;
		logic [7:0] arg1_num;
		logic [7:0] arg2_src;
		logic [7:0] arg2_num;
		logic [7:0] oper;
	} lbts_cond_type;

	localparam lbts_cond_type COND_RESET = '{SRC_UNUSED, 8'h00, SRC_UNUSED, 8'h00, CMP_EQ};

	typedef struct packed {
		logic [31:0] value;
		logic err;
		logic unavail;
	} lbts_arg_type;

	typedef struct packed {
		logic [31:0] value;
		logic no_axis;
	} lbts_lut_type;

	typedef struct packed {
		logic [31:0] value;
		logic not_avail;
	} lbts_out_type;

	typedef struct packed {
		logic [7:0] arg1_src;
		logic [7:0] arg1_num;
		logic [7:0] arg2_src;
		logic [7:0] arg2_num;
	} lbts_req_type;

	typedef struct packed {
		logic region;
		logic [1:0] blk;
		logic [1:0] tbl;
		logic [1:0] cnd;
		logic [2:0] sub;
	} lbts_cond_addr_type;

	typedef struct packed {
		logic [5:0] page;
		logic [1:0] blk;
		logic [1:0] lane;
	} lbts_misc_addr_type;

	function automatic logic [5:0] lbts_cond_idx(input logic [1:0] b, input logic [1:0] t,
			input logic [1:0] c);
		lbts_cond_idx = 6'(b * NUM_TBL * NUM_CND + t * NUM_CND + c);
	endfunction : lbts_cond_idx
endpackage : lbts_pkg

/* verilog/lbts_selector.sv */
// Logic block table selector: condition sweep, table choice and block outputs
// Function
// RL1: Four blocks, three tables, three conditions each
// RL2: Each condition evaluated before table combining
// RL3: Condition holds five byte fields plus highest index
// RL4: First argument always another block output
// RL5: Second argument block output or constant entry
// RL6: Software sets constants at first argument resolution
// RL7: Operator codes equal through less-or-equal
// RL8: Operator resets to equal
// RL9: Sources reset unused; unused gives not-applicable
// RL10: Results false, true, error, not-applicable
// RL11: Combiner codes default, and, or, mixes
// RL12: Tables A, B reset and; C default
// RL13: Default-table combiner selects table unconditionally
// RL14: All-and: not-applicable counts true
// RL15: All-or: any true selects
// RL16: And-then-or: one and two, or three
// RL17: Or-then-and: three with one or two
// RL18: Tables A, B, C in order, first wins
// RL19: Nothing selected falls back to table A
// RL20: Software puts default table on highest table
// RL21: Selected table number readable, updated on change
// RL22: Per-block enable, all disabled at reset
// RL23: Selected lookup table output is block output
// RL24: No axis source gives not-available output
// RL25: Everything re-evaluated every sweep
`timescale 1ns/100ps
module lbts_selector
	import lbts_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic [9:0] i_addr,
	input wire logic [7:0] i_wr_data,
	input wire logic i_wr_stb,
	input wire logic i_rd_stb,
	output logic [7:0] o_rd_data,
	output lbts_req_type o_arg_req,
	input wire lbts_arg_type i_arg1,
	input wire lbts_arg_type i_arg2,
	input wire logic [31:0] i_const_value,
	output logic [7:0] o_lut_idx,
	input wire lbts_lut_type i_lut,
	output lbts_out_type [NUM_BLK-1:0] o_block_out,
	output logic [NUM_BLK-1:0][1:0] o_selected_table
);
	typedef struct packed {
		logic [NUM_BLK-1:0] enable;
		logic [NUM_BLK-1:0][NUM_TBL-1:0][7:0] logic_op;
		logic [NUM_BLK-1:0][NUM_TBL-1:0][7:0] lut_num;
		logic [1:0] s_blk;
		logic [1:0] s_tbl;
		logic [1:0] s_cnd;
		logic p_vld;
		logic [1:0] p_blk;
		logic [1:0] p_tbl;
		logic [1:0] p_cnd;
		logic [1:0][1:0] res;
		logic [1:0] hit;
		logic [NUM_BLK-1:0][1:0] sel;
		logic [1:0] o_blk;
		lbts_out_type [NUM_BLK-1:0] out;
		logic [7:0] lut_idx;
		logic rd_mem;
		logic [7:0] rd_misc;
	} lbts_state_type;

	lbts_state_type q;
	lbts_state_type d;
	lbts_cond_addr_type ca;
	lbts_misc_addr_type ma;
	lbts_cond_type ev_word;
	logic [7:0] mem_rd;
	logic cond_ok;
	logic mem_wr;
	logic [1:0] cur_res;

	// Compare first argument against second under the operator code
	function automatic logic [1:0] eval_cond(input lbts_cond_type c, input lbts_arg_type a1,
			input lbts_arg_type a2, input logic [31:0] cval);
		logic [31:0] b;
		logic b_err;
		logic b_na;
		logic t;
		b = a2.value;
		b_err = a2.err;
		b_na = a2.unavail;
		t = 1'b0;
		if (c.arg2_src == SRC_CONST) begin // RL5
			b = cval;
			b_err = 1'b0;
			b_na = 1'b0;
		end
		if (c.arg1_src == SRC_UNUSED || c.arg2_src == SRC_UNUSED) begin // RL9
			eval_cond = RES_NA;
		end else if (a1.err || b_err) begin // RL10
			eval_cond = RES_ERROR;
		end else if (a1.unavail || b_na) begin // RL10
			eval_cond = RES_NA;
		end else begin
			eval_cond = RES_FALSE;
			unique case (c.oper) // RL7
				CMP_EQ: t = $signed(a1.value) == $signed(b);
				CMP_NE: t = $signed(a1.value) != $signed(b);
				CMP_GT: t = $signed(a1.value) > $signed(b);
				CMP_GE: t = $signed(a1.value) >= $signed(b);
				CMP_LT: t = $signed(a1.value) < $signed(b);
				CMP_LE: t = $signed(a1.value) <= $signed(b);
				default: eval_cond = RES_ERROR;
			endcase
			if (c.oper <= CMP_LE) begin
				eval_cond = t ? RES_TRUE : RES_FALSE; // RL10
			end
		end
	endfunction : eval_cond

	// Combine three condition results under the table's combiner code
	function automatic logic combine(input logic [7:0] op, input logic [1:0] r1,
			input logic [1:0] r2, input logic [1:0] r3);
		logic t1;
		logic t2;
		logic t3;
		t1 = r1 == RES_TRUE;
		t2 = r2 == RES_TRUE;
		t3 = r3 == RES_TRUE;
		unique case (op) // RL11
			LOGIC_DEFAULT: combine = 1'b1; // RL13
			LOGIC_AND_ALL: combine = (r1 != RES_FALSE) && (r1 != RES_ERROR) &&
				(r2 != RES_FALSE) && (r2 != RES_ERROR) &&
				(r3 != RES_FALSE) && (r3 != RES_ERROR); // RL14
			LOGIC_OR_ALL: combine = t1 || t2 || t3; // RL15
			LOGIC_AND_OR: combine = (t1 && t2) || t3; // RL16
			LOGIC_OR_AND: combine = (t1 || t2) && t3; // RL17
			// Unknown combiner codes never select, so the fallback still applies
			default: combine = 1'b0;
		endcase
	endfunction : combine

	// First hit in table order wins; no hit falls back to table A
	function automatic logic [1:0] pick(input logic hit_a, input logic hit_b,
			input logic hit_c);
		if (hit_a) begin // RL18
			pick = TABLE_A;
		end else if (hit_b) begin
			pick = TABLE_B;
		end else if (hit_c) begin
			pick = TABLE_C;
		end else begin
			pick = TABLE_A; // RL19
		end
	endfunction : pick

	assign ca = lbts_cond_addr_type'(i_addr);
	assign ma = lbts_misc_addr_type'(i_addr);
	assign cond_ok = !ca.region && ca.tbl <= IDX_LAST && ca.cnd <= IDX_LAST &&
		ca.sub <= SUB_OPERATOR;
	assign mem_wr = i_wr_stb && cond_ok && ca.sub != SUB_HIGHEST;

	lbts_cond_mem u_cond_mem (
		.i_ref_clk(i_ref_clk),
		.i_sys_rst(i_sys_rst),
		.i_wr_en(mem_wr),
		.i_wr_idx(lbts_cond_idx(ca.blk, ca.tbl, ca.cnd)),
		.i_wr_sub(ca.sub),
		.i_wr_data(i_wr_data),
		.i_bus_idx(lbts_cond_idx(ca.blk, ca.tbl, ca.cnd)),
		.i_bus_sub(ca.sub),
		.o_bus_data(mem_rd),
		.i_ev_idx(lbts_cond_idx(q.s_blk, q.s_tbl, q.s_cnd)),
		.o_ev_word(ev_word)
	);

	// Argument lookup answers within the same cycle from neighbouring logic
	assign o_arg_req = '{ev_word.arg1_src, ev_word.arg1_num,
		ev_word.arg2_src, ev_word.arg2_num}; // RL4 RL5
	assign cur_res = eval_cond(ev_word, i_arg1, i_arg2, i_const_value);

	assign o_lut_idx = q.lut_idx; // RL23
	assign o_block_out = q.out;
	assign o_selected_table = q.sel;
	assign o_rd_data = q.rd_mem ? mem_rd : q.rd_misc;

	always_comb begin
		logic hit_now;
		logic [1:0] nxt_tbl;
		hit_now = 1'b0;
		nxt_tbl = 2'h0;
		d = q;

		// Sweep one condition per cycle over every block, table and condition
		d.s_cnd = q.s_cnd + 2'h1; // RL25
		if (q.s_cnd == IDX_LAST) begin
			d.s_cnd = 2'h0;
			d.s_tbl = q.s_tbl + 2'h1;
			if (q.s_tbl == IDX_LAST) begin
				d.s_tbl = 2'h0;
				d.s_blk = q.s_blk + 2'h1; // RL1
			end
		end
		d.p_vld = 1'b1;
		d.p_blk = q.s_blk;
		d.p_tbl = q.s_tbl;
		d.p_cnd = q.s_cnd;

		// Later tables are still swept but cannot override an earlier hit
		if (q.p_vld) begin
			if (q.p_cnd != IDX_LAST) begin
				d.res[q.p_cnd[0]] = cur_res; // RL2
			end else begin
				hit_now = combine(q.logic_op[q.p_blk][q.p_tbl], q.res[0], q.res[1], cur_res);
				if (q.p_tbl != IDX_LAST) begin
					d.hit[q.p_tbl[0]] = hit_now;
				end else if (q.enable[q.p_blk]) begin
					d.sel[q.p_blk] = pick(q.hit[0], q.hit[1], hit_now); // RL18 RL21
				end else begin
					d.sel[q.p_blk] = TABLE_NONE; // RL22
				end
			end
		end

		// Block outputs are refreshed round robin, one block per cycle
		d.o_blk = q.o_blk + 2'h1;
		if (q.enable[q.o_blk] && q.sel[q.o_blk] != TABLE_NONE) begin
			d.out[q.o_blk].value = i_lut.value; // RL23
			d.out[q.o_blk].not_avail = i_lut.no_axis; // RL24
		end else begin
			d.out[q.o_blk].value = 32'h0000_0000;
			d.out[q.o_blk].not_avail = 1'b1; // RL22
		end

		if (i_wr_stb && ca.region) begin
			if (i_addr == ADDR_ENABLE) begin
				d.enable = i_wr_data[NUM_BLK-1:0]; // RL22
			end else if (ma.page == PAGE_OP && ma.lane <= IDX_LAST) begin
				d.logic_op[ma.blk][ma.lane] = i_wr_data; // RL11
			end else if (ma.page == PAGE_LUT && ma.lane <= IDX_LAST) begin
				d.lut_num[ma.blk][ma.lane] = i_wr_data;
			end
		end

		d.rd_mem = 1'b0;
		d.rd_misc = 8'h00;
		if (i_rd_stb) begin
			if (cond_ok) begin
				d.rd_mem = 1'b1; // RL3
			end else if (ca.region) begin
				if (i_addr == ADDR_ENABLE) begin
					d.rd_misc = 8'(q.enable);
				end else if (ma.page == PAGE_OP && ma.lane <= IDX_LAST) begin
					d.rd_misc = q.logic_op[ma.blk][ma.lane];
				end else if (ma.page == PAGE_LUT && ma.lane <= IDX_LAST) begin
					d.rd_misc = q.lut_num[ma.blk][ma.lane];
				end else if (ma.page == PAGE_SEL && ma.lane == 2'h0) begin
					d.rd_misc = 8'(q.sel[ma.blk]); // RL21
				end else if (ma.page == PAGE_OUT) begin
					d.rd_misc = q.out[ma.blk].value[ma.lane*BYTE_W +: BYTE_W];
				end else if (ma.page == PAGE_NA && ma.lane == 2'h0) begin
					d.rd_misc = 8'(q.out[ma.blk].not_avail); // RL24
				end
			end
		end

		// Index is registered one cycle ahead, so the lookup request leaves a flip-flop
		if (d.sel[d.o_blk] != TABLE_NONE) begin
			nxt_tbl = d.sel[d.o_blk] - TABLE_A;
		end
		d.lut_idx = d.lut_num[d.o_blk][nxt_tbl]; // RL23
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			q <= '{
				enable: '0, // RL22
				logic_op: {NUM_BLK{OP_RESET}}, // RL12
				lut_num: LUT_RESET,
				s_blk: 2'h0,
				s_tbl: 2'h0,
				s_cnd: 2'h0,
				p_vld: 1'b0,
				p_blk: 2'h0,
				p_tbl: 2'h0,
				p_cnd: 2'h0,
				res: '0,
				hit: '0,
				sel: '0,
				o_blk: 2'h0,
				out: {NUM_BLK{33'h0_0000_0001}},
				lut_idx: LUT_RESET[0][0],
				rd_mem: 1'b0,
				rd_misc: 8'h00
			};
		end else begin
			q <= d;
		end
	end
endmodule : lbts_selector
